// file: emst_counter.sv
`timescale 1ns/1ps
module emst_counter
   import emst_pkg::*;
#(
   parameter int W = 5
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic zero
);
   typedef struct packed {logic [W-1:0] cnt;} emst_cnt_s;
   emst_cnt_s st;
   emst_cnt_s next_st;
   always_comb
   begin
      next_st = st;
      if (load)
      begin
         next_st.cnt = value;
      end
      else if (st.cnt != '0)
      begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign zero = (st.cnt == '0);
endmodule : emst_counter

// file: emst_pkg.sv
package emst_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] EMST_TIMING_ADDR = 8'hAF;
   localparam logic [7:0] EMST_TIMING_RESET = 8'hFF;
   localparam int EMST_SETUP_MSB = 7;
   localparam int EMST_SETUP_LSB = 6;
   localparam int EMST_WIDTH_MSB = 5;
   localparam int EMST_WIDTH_LSB = 2;
   localparam int EMST_HOLD_MSB = 1;
   localparam int EMST_HOLD_LSB = 0;
   // ----------------------------------------
   // configuration field
   // ----------------------------------------
   localparam int EMST_STYLE_BIT = 2;
   localparam logic [2:0] EMST_CFG_MUX_BANK = 3'h2;
   localparam logic [2:0] EMST_CFG_NMX_BANK = 3'h6;
   localparam logic [1:0] EMST_LATCH_RESET = 2'h3;
   // ----------------------------------------
   // one less than the five fixed cycles of an access
   // ----------------------------------------
   localparam logic [2:0] EMST_OVERHEAD = 3'h4;
   typedef enum logic [2:0] {EMST_IDLE, EMST_LHI, EMST_LLO, EMST_SETUP, EMST_STROBE, EMST_HOLD, EMST_TAIL} emst_state_e;
endpackage : emst_pkg

// file: emst_sram_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external memory and address latch
// ----------------------------------------
module emst_sram_model
(
   input wire logic ref_clk,
   input wire logic [7:0] addrLo,
   input wire logic addrLoOe,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic ale,
   output logic [7:0] dataIn
);
   logic [7:0] mem [0:255];
   logic [7:0] latched = 8'h00;
   logic [7:0] junk = 8'h5A;
   logic [7:0] cellAddr;
   // low byte comes from the latch when the pins are shared
   assign cellAddr = addrLoOe ? addrLo : latched;
   // outside a read the lines wander, so stale data never passes
   assign dataIn = !rdN ? mem[cellAddr] : junk;
   always @(posedge ref_clk)
   begin
      junk <= junk + 8'h35;
      if (ale && dataOe)
      begin
         latched <= dataOut;
      end
      if (!wrN && dataOe)
      begin
         mem[cellAddr] <= dataOut;
      end
   end
endmodule : emst_sram_model

// file: emst_timing.sv
`timescale 1ns/1ps
module emst_timing
   import emst_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sfrWrite,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   input wire logic [2:0] ext_bus_configuration,
   input wire logic [1:0] latchWidthCode,
   input wire logic [7:0] bankByte,
   input wire logic accReq,
   input wire logic accWrite,
   input wire logic accWide,
   input wire logic [15:0] accAddr,
   input wire logic [7:0] accWdata,
   output logic accBusy,
   output logic accDone,
   output logic [7:0] accRdata,
   output logic [7:0] addrHi,
   output logic addrHiOe,
   output logic [7:0] addrLo,
   output logic addrLoOe,
   output logic [7:0] dataOut,
   input wire logic [7:0] dataIn,
   output logic dataOe,
   output logic rdN,
   output logic wrN,
   output logic ale
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] ext_bus_timing_control;
      emst_state_e phase;
      logic mux;
      logic bankSel;
      logic isWrite;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic done;
      logic wide;
   } emst_state_s;
   emst_state_s st;
   emst_state_s next_st;
   logic cntLoad;
   logic [4:0] cntValue;
   logic cntZero;
   logic [1:0] addr_setup_cycles;
   logic [3:0] strobe_width_code;
   logic [1:0] addr_hold_cycles;
   logic bus_style_select;
   assign addr_setup_cycles = st.ext_bus_timing_control[EMST_SETUP_MSB:EMST_SETUP_LSB];
   assign strobe_width_code = st.ext_bus_timing_control[EMST_WIDTH_MSB:EMST_WIDTH_LSB];
   assign addr_hold_cycles = st.ext_bus_timing_control[EMST_HOLD_MSB:EMST_HOLD_LSB];
   assign bus_style_select = ext_bus_configuration[EMST_STYLE_BIT];
   // one shared down-counter times every phase except idle
   emst_counter #(.W(5)) u_cnt (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(cntLoad),
      .value(cntValue),
      .zero(cntZero)
   );
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      cntLoad = 1'b0;
      cntValue = 5'h00;
      if (sfrWrite && sfrAddr == EMST_TIMING_ADDR)
      begin
         next_st.ext_bus_timing_control = sfrWdata;
      end
      unique case (st.phase)
         EMST_IDLE:
         begin
            if (accReq)
            begin
               next_st.mux = ~bus_style_select;
               next_st.bankSel = ~accWide && (ext_bus_configuration == EMST_CFG_MUX_BANK
                  || ext_bus_configuration == EMST_CFG_NMX_BANK);
               next_st.isWrite = accWrite;
               next_st.addr = accWide ? accAddr : {bankByte, accAddr[7:0]};
               next_st.wdata = accWdata;
               next_st.wide = accWide;
               cntLoad = 1'b1;
               if (~bus_style_select)
               begin
                  next_st.phase = EMST_LHI;
                  cntValue = {3'h0, latchWidthCode};
               end
               else
               begin
                  next_st.phase = EMST_SETUP;
                  cntValue = {3'h0, addr_setup_cycles};
               end
            end
         end
         EMST_LHI:
         begin
            if (cntZero)
            begin
               next_st.phase = EMST_LLO;
               cntLoad = 1'b1;
               cntValue = {3'h0, latchWidthCode};
            end
         end
         EMST_LLO:
         begin
            if (cntZero)
            begin
               next_st.phase = EMST_SETUP;
               cntLoad = 1'b1;
               cntValue = {3'h0, addr_setup_cycles};
            end
         end
         EMST_SETUP:
         begin
            if (cntZero)
            begin
               next_st.phase = EMST_STROBE;
               cntLoad = 1'b1;
               cntValue = {1'b0, strobe_width_code};
            end
         end
         EMST_STROBE:
         begin
            if (cntZero)
            begin
               next_st.rdata = dataIn;
               cntLoad = 1'b1;
               // a zero hold code skips the hold phase, so hold lasts exactly the code
               if (addr_hold_cycles == 2'h0)
               begin
                  next_st.phase = EMST_TAIL;
                  cntValue = {2'h0, EMST_OVERHEAD - 3'h2};
               end
               else
               begin
                  next_st.phase = EMST_HOLD;
                  cntValue = {3'h0, addr_hold_cycles - 2'h1};
               end
            end
         end
         EMST_HOLD:
         begin
            if (cntZero)
            begin
               next_st.phase = EMST_TAIL;
               cntLoad = 1'b1;
               // setup and strobe each carry one overhead cycle, the tail the other three
               cntValue = {2'h0, EMST_OVERHEAD - 3'h2};
            end
         end
         EMST_TAIL:
         begin
            if (cntZero)
            begin
               next_st.phase = EMST_IDLE;
               next_st.done = 1'b1;
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st <= '0;
         st.ext_bus_timing_control <= EMST_TIMING_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end
   // ----------------------------------------
   // pins
   // ----------------------------------------
   logic active;
   logic lowShared;
   assign active = st.phase inside {EMST_LHI, EMST_LLO, EMST_SETUP, EMST_STROBE, EMST_HOLD};
   // in multiplexed mode the low byte rides the data pins only while latching
   assign lowShared = st.mux && st.phase == EMST_LHI;
   assign sfrRdata = (sfrAddr == EMST_TIMING_ADDR) ? st.ext_bus_timing_control : 8'h00;
   assign accBusy = st.phase != EMST_IDLE;
   assign accDone = st.done;
   assign accRdata = st.rdata;
   assign ale = st.phase == EMST_LHI;
   assign rdN = ~(st.phase == EMST_STROBE && ~st.isWrite);
   assign wrN = ~(st.phase == EMST_STROBE && st.isWrite);
   assign addrHi = st.addr[15:8];
   // unbanked 8-bit access leaves the upper pins with the port latches
   assign addrHiOe = active && (st.wide || st.bankSel);
   assign addrLo = st.addr[7:0];
   assign addrLoOe = active && ~st.mux;
   assign dataOut = lowShared ? st.addr[7:0] : st.wdata;
   // write data stays through hold; muxed pins carry address while latching
   assign dataOe = lowShared || (active && st.isWrite && st.phase != EMST_LHI
      && st.phase != EMST_LLO);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_reset_timing: assert property (@(posedge ref_clk)
      $fell(rst) |-> st.ext_bus_timing_control == EMST_TIMING_RESET)
      else $error("timing register not all ones after reset");
   a_strobe_width: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rdN && wrN) && strobe_width_code == 4'h0 |=> (rdN && wrN))
      else $error("one-cycle strobe too long");
   a_strobe_min: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rdN && wrN) && strobe_width_code == 4'h1 |=> !(rdN && wrN) ##1 (rdN && wrN))
      else $error("two-cycle strobe wrong");
   a_setup_zero: assert property (@(posedge ref_clk) disable iff (rst)
      st.phase == EMST_IDLE && accReq && bus_style_select && addr_setup_cycles == 2'h0
      |=> ##1 st.phase == EMST_STROBE)
      else $error("zero setup not honoured");
   a_min_access: assert property (@(posedge ref_clk) disable iff (rst)
      st.phase == EMST_IDLE && accReq && bus_style_select && st.ext_bus_timing_control == 8'h00
      |=> ##5 accDone)
      else $error("shortest access not five cycles");
   a_ale_nonmux: assert property (@(posedge ref_clk) disable iff (rst) !st.mux && accBusy |-> !ale)
      else $error("latch strobe in non-multiplexed mode");
   a_ale_before: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(ale) |-> rdN && wrN && !(dataOe && st.phase == EMST_LLO))
      else $error("data driven during latch low time");
   a_hold_data: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(wrN) && addr_hold_cycles == 2'h1 |-> dataOe ##1 !dataOe)
      else $error("write data hold wrong");
   a_upper_pins: assert property (@(posedge ref_clk) disable iff (rst)
      addrHiOe |-> st.wide || ext_bus_configuration == EMST_CFG_MUX_BANK
      || ext_bus_configuration == EMST_CFG_NMX_BANK)
      else $error("upper pins driven without bank");
   a_order: assert property (@(posedge ref_clk) disable iff (rst)
      st.phase == EMST_STROBE |=> st.phase == EMST_STROBE
      || st.phase == (addr_hold_cycles == 2'h0 ? EMST_TAIL : EMST_HOLD))
      else $error("phase order broken");
   c_read: cover property (@(posedge ref_clk) $fell(rdN));
   c_write: cover property (@(posedge ref_clk) $fell(wrN));
   c_mux: cover property (@(posedge ref_clk) $rose(ale));
   c_bank: cover property (@(posedge ref_clk) st.bankSel && accBusy);
endmodule : emst_timing

// file: test_emst_timing.sv
`timescale 1ns/1ps
module test_emst_timing import emst_pkg::*;;
   logic ref_clk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, accReq = 1'b0, accWrite = 1'b0, accWide = 1'b0;
   logic [7:0] sfrAddr = 8'hAF, sfrWdata = 8'h00, bankByte = 8'h00, accWdata = 8'h00;
   logic [2:0] cfg = 3'h5;
   logic [1:0] lw = 2'h3;
   logic [15:0] accAddr = 16'h0000;
   logic [7:0] sfrRdata, accRdata, addrHi, addrLo, dataOut, dataIn;
   logic accBusy, accDone, addrHiOe, addrLoOe, dataOe, rdN, wrN, ale;
   int seed, err_total, comparisons, busy, strb, aleHi;
   logic hiOe;
   logic [7:0] hiSeen, tc;
   logic [2:0] cfgs [0:5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
   always #5 ref_clk = ~ref_clk;
   emst_timing dut (.ref_clk(ref_clk), .rst(rst), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata), .ext_bus_configuration(cfg), .latchWidthCode(lw), .bankByte(bankByte),
      .accReq(accReq), .accWrite(accWrite), .accWide(accWide), .accAddr(accAddr), .accWdata(accWdata),
      .accBusy(accBusy), .accDone(accDone), .accRdata(accRdata), .addrHi(addrHi), .addrHiOe(addrHiOe),
      .addrLo(addrLo), .addrLoOe(addrLoOe), .dataOut(dataOut), .dataIn(dataIn), .dataOe(dataOe),
      .rdN(rdN), .wrN(wrN), .ale(ale));
   emst_sram_model mem (.ref_clk(ref_clk), .addrLo(addrLo), .addrLoOe(addrLoOe), .dataOut(dataOut),
      .dataOe(dataOe), .rdN(rdN), .wrN(wrN), .ale(ale), .dataIn(dataIn));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   function automatic logic [15:0] exp_len(input logic [7:0] t, input logic [2:0] c, input logic [1:0] l);
      exp_len = 16'(t[7:6]) + 16'(t[5:2]) + 16'(t[1:0]) + 16'h0005;
      if (!c[EMST_STYLE_BIT])
      begin
         exp_len = exp_len + 16'(2 * (l + 1));
      end
   endfunction : exp_len
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWrite = 1'b1;
      @(negedge ref_clk);
      sfrWrite = 1'b0;
   endtask : sfr_wr
   // one access; counts busy, strobe and latch cycles up to the done pulse
   task automatic access(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d);
      busy = 0;
      strb = 0;
      aleHi = 0;
      hiOe = 1'b0;
      hiSeen = 8'h00;
      accReq = 1'b1;
      accWrite = wr;
      accWide = wide;
      accAddr = a;
      accWdata = d;
      @(negedge ref_clk);
      accReq = 1'b0;
      for (int i = 0; i < 80; i++)
      begin
         busy += int'(accBusy === 1'b1);
         strb += int'(rdN === 1'b0 || wrN === 1'b0);
         aleHi += int'(ale === 1'b1);
         if (addrHiOe === 1'b1)
         begin
            hiOe = 1'b1;
            hiSeen = addrHi;
         end
         if (accDone === 1'b1)
         begin
            break;
         end
         @(negedge ref_clk);
      end
      check("done pulse", 16'h0001, 16'(accDone));
      check("busy cycles", exp_len(tc, cfg, lw), 16'(busy));
      check("strobe cycles", 16'(tc[5:2]) + 16'h0001, 16'(strb));
      check("latch high cycles", cfg[EMST_STYLE_BIT] ? 16'h0000 : 16'(lw) + 16'h0001, 16'(aleHi));
      check("upper enable", 16'(wide || cfg == EMST_CFG_MUX_BANK || cfg == EMST_CFG_NMX_BANK), 16'(hiOe));
      check("upper byte", hiOe ? 16'(wide ? a[15:8] : bankByte) : 16'h0000, 16'(hiSeen));
   endtask : access
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      seed = 55447;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      check("timing reset", 16'(EMST_TIMING_RESET), 16'(sfrRdata));
      sfrAddr = 8'h10;
      #1 check("unmapped read", 16'h0000, 16'(sfrRdata));
      @(negedge ref_clk);
      // corners in tests 0, 1 and 3: shortest, longest, shortest again; random mixes otherwise
      for (int n = 0; n < 24; n++)
      begin
         logic [15:0] a;
         logic [7:0] d;
         tc = (n == 0 || n == 3) ? 8'h00 : (n == 1) ? 8'hFF : 8'($random(seed));
         cfg = cfgs[n % 6];
         lw = 2'($random(seed));
         bankByte = 8'($random(seed));
         a = 16'($random(seed));
         d = 8'($random(seed));
         sfr_wr(EMST_TIMING_ADDR, tc);
         check("timing readback", 16'(tc), 16'(sfrRdata));
         access(1'b1, n[3], a, d);
         access(1'b0, n[3], a, d);
         check("read data", 16'(d), 16'(accRdata));
         $display("test %0d cfg %h timing %h done", n, cfg, tc);
      end
      // mid-run reset must bring back the longest timing
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      check("timing after reset", 16'(EMST_TIMING_RESET), 16'(sfrRdata));
      tc = EMST_TIMING_RESET;
      access(1'b0, 1'b1, 16'h1234, 8'h00);
      $display("test reset cfg %h timing %h done", cfg, tc);
      close_out();
   end
   initial
   begin
      #100000;
      err_total++;
      close_out();
   end
endmodule : test_emst_timing
